// ===== logic/exv_pkg.sv
// Package of constants and carrier types for the exception vector selector
package exv_pkg;

   ////////////////////////////////////////////////////////////////////////////
   // Exception sources, index order is the fixed priority (0 highest)
   localparam int EXV_NSRC = 12;
   localparam int EXV_IDX_W = 4;
   localparam int SRC_IFETCH = 0;
   localparam int SRC_DSI = 1;
   localparam int SRC_ALIGN = 2;
   localparam int SRC_PROG = 3;
   localparam int SRC_FPU = 4;
   localparam int SRC_SYSCALL = 5;
   localparam int SRC_TRACE = 6;
   localparam int SRC_FPA = 7;
   localparam int SRC_IMPL_LO = 8;
   localparam int SRC_IMPL_HI = 9;
   localparam int SRC_EXT = 10;
   localparam int SRC_DEC = 11;

   ////////////////////////////////////////////////////////////////////////////
   // Vector offsets
   localparam int EXV_OFF_W = 14;
   localparam logic [13:0] OFF_DSI = 14'h0300;
   localparam logic [13:0] OFF_IFETCH = 14'h0400;
   localparam logic [13:0] OFF_EXT = 14'h0500;
   localparam logic [13:0] OFF_ALIGN = 14'h0600;
   localparam logic [13:0] OFF_PROG = 14'h0700;
   localparam logic [13:0] OFF_FPU = 14'h0800;
   localparam logic [13:0] OFF_DEC = 14'h0900;
   localparam logic [13:0] OFF_IMPL_LO = 14'h0a00;
   localparam logic [13:0] OFF_RSVD_B = 14'h0b00;
   localparam logic [13:0] OFF_SYSCALL = 14'h0c00;
   localparam logic [13:0] OFF_TRACE = 14'h0d00;
   localparam logic [13:0] OFF_FPA = 14'h0e00;
   localparam logic [13:0] OFF_RSVD_LO = 14'h0e10;
   localparam logic [13:0] OFF_RSVD_HI = 14'h0fff;
   localparam logic [13:0] OFF_IMPL_HI = 14'h1000;
   localparam logic [13:0] OFF_IMPL_TOP = 14'h2fff;
   localparam logic [EXV_NSRC-1:0][13:0] EXV_OFF_TBL = {
      OFF_DEC, OFF_EXT, OFF_IMPL_HI, OFF_IMPL_LO, OFF_FPA, OFF_TRACE,
      OFF_SYSCALL, OFF_FPU, OFF_PROG, OFF_ALIGN, OFF_DSI, OFF_IFETCH};

   ////////////////////////////////////////////////////////////////////////////
   // Optional exceptions present in this build
   localparam logic ALIGN_IMPL = 1'b1;
   localparam logic TRACE_IMPL = 1'b1;
   localparam logic FPA_IMPL = 1'b1;

   ////////////////////////////////////////////////////////////////////////////
   // APB register map and reset values
   localparam int APB_AW = 12;
   localparam logic [11:0] REG_MSTATE = 12'h000;
   localparam logic [11:0] REG_BASE = 12'h004;
   localparam logic [11:0] REG_STATUS = 12'h008;
   localparam logic [11:0] REG_MASK = 12'h00c;
   localparam logic [11:0] REG_SAVED = 12'h010;
   localparam logic [11:0] REG_PEND = 12'h014;
   localparam int BASE_LSB = 14;
   localparam logic [3:0] MSTATE_RST = 4'h0;
   localparam logic [17:0] BASE_RST = 18'h00000;
   localparam logic [11:0] MASK_RST = 12'h000;

   ////////////////////////////////////////////////////////////////////////////
   // Carrier types
   typedef struct packed {
      logic branch_trace_enable;
      logic single_step_enable;
      logic float_available;
      logic external_irq_enable;
   } exv_mstate_t;

   typedef struct packed {
      logic fetch_fault;
      logic data_fault;
      logic align_fault;
      logic prog_fault;
      logic [3:0] prog_cause;
      logic fp_instr;
      logic system_call_instr;
      logic instr_done;
      logic instr_is_rfi;
      logic branch_done;
      logic fp_assist;
      logic impl_lo_req;
      logic impl_hi_req;
      logic [4:0] impl_sel;
      logic dec_msb;
   } exv_core_evt_t;

endpackage

// ===== logic/exv_prio_pick.sv
// Fixed priority picker: one-hot grant and index of the lowest set request
`timescale 1ns/10ps
`default_nettype none
module exv_prio_pick #(
   parameter int N = 12,
   parameter int W = 4
) (
   // Requests, bit 0 wins
   input wire logic [N-1:0] req,
   // Result
   output logic [N-1:0] grant,
   output logic [W-1:0] idx
);

   logic [N:0] lower;
   logic [W-1:0] idx_acc [N+1];

   assign lower[0] = 1'b0;
   assign idx_acc[0] = '0;

   genvar i;
   generate
      for (i = 0; i < N; i++) begin : g_ent
         assign lower[i+1] = lower[i] | req[i];
         assign grant[i] = req[i] & ~lower[i];
         assign idx_acc[i+1] = idx_acc[i] | (grant[i] ? W'(i) : '0);
      end
   endgenerate

   assign idx = idx_acc[N];

endmodule
`default_nettype wire

// ===== logic/exv_vector_select.sv
// Exception recognition and vector selection with APB control registers
//
// Our own choices: the APB interface to the registers and the register addresses.
`timescale 1ns/10ps
`default_nettype none
module exv_vector_select (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Core events and external request pin
   input wire exv_pkg::exv_core_evt_t core_evt,
   input wire logic ext_irq_pin,
   // Redirect to fetch unit
   output logic exc_take,
   output logic [31:0] exc_vector,
   output logic [13:0] exc_offset,
   // Machine state and interrupt
   output var exv_pkg::exv_mstate_t machine_state_reg,
   output logic irq
);

   localparam int N = exv_pkg::EXV_NSRC;

   exv_pkg::exv_mstate_t mstate_ff;
   logic [17:0] base_ff;
   logic [N-1:0] status_ff;
   logic [N-1:0] mask_ff;
   logic [3:0] saved_state_reg_ff;
   logic [3:0] prog_cause_ff;
   logic [4:0] impl_sel_ff;
   logic [N-1:0] pend_ff;
   logic [N-1:0] nxt_pend;
   logic [N-1:0] evt;
   logic [N-1:0] cand;
   logic [N-1:0] req;
   logic [N-1:0] grant;
   logic [exv_pkg::EXV_IDX_W-1:0] pick_idx;
   logic [13:0] pick_off;
   logic take_now;
   logic ext_s1_ff;
   logic ext_s2_ff;
   logic dec_prev_ff;
   logic take_ff;
   logic [13:0] off_ff;
   logic [31:0] vec_ff;
   logic irq_ff;
   logic [31:0] prdata_ff;
   logic [31:0] rd_mux;
   logic mapped;
   logic wr_en;

   ////////////////////////////////////////////////////////////////////////////
   // External pin synchroniser
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         ext_s1_ff <= 1'b0;
         ext_s2_ff <= 1'b0;
      end else begin
         ext_s1_ff <= ext_irq_pin;
         ext_s2_ff <= ext_s1_ff;
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         dec_prev_ff <= 1'b0;
      end else begin
         dec_prev_ff <= core_evt.dec_msb;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Event detection
   always_comb begin
      evt = '0;
      evt[exv_pkg::SRC_IFETCH] = core_evt.fetch_fault;
      evt[exv_pkg::SRC_DSI] = core_evt.data_fault;
      // Without the option the core must finish misaligned accesses itself
      evt[exv_pkg::SRC_ALIGN] = exv_pkg::ALIGN_IMPL &
         core_evt.align_fault;
      evt[exv_pkg::SRC_PROG] = core_evt.prog_fault;
      evt[exv_pkg::SRC_FPU] = core_evt.fp_instr &
         ~mstate_ff.float_available;
      evt[exv_pkg::SRC_SYSCALL] = core_evt.system_call_instr;
      evt[exv_pkg::SRC_TRACE] = exv_pkg::TRACE_IMPL &
         ((mstate_ff.single_step_enable & core_evt.instr_done &
         ~core_evt.instr_is_rfi) |
         (mstate_ff.branch_trace_enable & core_evt.branch_done));
      evt[exv_pkg::SRC_FPA] = exv_pkg::FPA_IMPL & core_evt.fp_assist;
      evt[exv_pkg::SRC_IMPL_LO] = core_evt.impl_lo_req;
      evt[exv_pkg::SRC_IMPL_HI] = core_evt.impl_hi_req;
      evt[exv_pkg::SRC_DEC] = core_evt.dec_msb & ~dec_prev_ff;
   end

   ////////////////////////////////////////////////////////////////////////////
   // Pending state and request gating
   always_comb begin
      cand = pend_ff | evt;
      // External request is a level, never latched: it drops when the pin does
      cand[exv_pkg::SRC_EXT] = ext_s2_ff;
      req = cand;
      req[exv_pkg::SRC_EXT] = cand[exv_pkg::SRC_EXT] &
         mstate_ff.external_irq_enable;
      req[exv_pkg::SRC_DEC] = cand[exv_pkg::SRC_DEC] &
         mstate_ff.external_irq_enable;
   end

   exv_prio_pick #(
      .N(N),
      .W(exv_pkg::EXV_IDX_W)
   ) u_pick (
      .req(req),
      .grant(grant),
      .idx(pick_idx)
   );

   assign take_now = |req;

   // Losers other than the external request stay pending and compete again next cycle
   always_comb begin
      nxt_pend = cand & ~grant;
      nxt_pend[exv_pkg::SRC_EXT] = 1'b0;
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         pend_ff <= '0;
      end else begin
         pend_ff <= nxt_pend;
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         prog_cause_ff <= 4'h0;
         impl_sel_ff <= 5'h00;
      end else begin
         if (evt[exv_pkg::SRC_PROG]) begin
            prog_cause_ff <= core_evt.prog_cause;
         end
         if (evt[exv_pkg::SRC_IMPL_HI]) begin
            impl_sel_ff <= core_evt.impl_sel;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Offset and handler address
   always_comb begin
      pick_off = exv_pkg::EXV_OFF_TBL[pick_idx];
      if (grant[exv_pkg::SRC_IMPL_HI]) begin
         pick_off = exv_pkg::OFF_IMPL_HI + {1'b0,
            (evt[exv_pkg::SRC_IMPL_HI] ? core_evt.impl_sel : impl_sel_ff),
            8'h00};
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         take_ff <= 1'b0;
         off_ff <= 14'h0000;
         vec_ff <= 32'h0000_0000;
      end else begin
         take_ff <= take_now;
         off_ff <= pick_off;
         vec_ff <= {base_ff, pick_off};
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         saved_state_reg_ff <= 4'h0;
      end else if (grant[exv_pkg::SRC_PROG]) begin
         saved_state_reg_ff <= evt[exv_pkg::SRC_PROG] ?
            core_evt.prog_cause : prog_cause_ff;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // APB slave, zero wait states; read data is sampled in the setup cycle
   assign wr_en = psel & penable & pwrite;
   assign mapped = (paddr == exv_pkg::REG_MSTATE) |
      (paddr == exv_pkg::REG_BASE) | (paddr == exv_pkg::REG_STATUS) |
      (paddr == exv_pkg::REG_MASK) | (paddr == exv_pkg::REG_SAVED) |
      (paddr == exv_pkg::REG_PEND);
   assign pready = 1'b1;
   assign pslverr = psel & penable & ~mapped;

   always_comb begin
      rd_mux = 32'h0000_0000;
      case (paddr)
         exv_pkg::REG_MSTATE: rd_mux = {28'h0000000, mstate_ff};
         exv_pkg::REG_BASE: rd_mux = {base_ff, 14'h0000};
         exv_pkg::REG_STATUS: rd_mux = {20'h00000, status_ff};
         exv_pkg::REG_MASK: rd_mux = {20'h00000, mask_ff};
         exv_pkg::REG_SAVED: rd_mux = {28'h0000000, saved_state_reg_ff};
         exv_pkg::REG_PEND: rd_mux = {20'h00000, pend_ff};
         default: rd_mux = 32'h0000_0000;
      endcase
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         prdata_ff <= 32'h0000_0000;
      end else if (psel & ~penable) begin
         prdata_ff <= rd_mux;
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         mstate_ff <= exv_pkg::MSTATE_RST;
         base_ff <= exv_pkg::BASE_RST;
         mask_ff <= exv_pkg::MASK_RST;
      end else if (wr_en) begin
         if (paddr == exv_pkg::REG_MSTATE) begin
            mstate_ff <= pwdata[3:0];
         end
         if (paddr == exv_pkg::REG_BASE) begin
            base_ff <= pwdata[31:exv_pkg::BASE_LSB];
         end
         if (paddr == exv_pkg::REG_MASK) begin
            mask_ff <= pwdata[N-1:0];
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Interrupt status: a take in the clearing cycle survives the clear
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         status_ff <= '0;
      end else if (wr_en && paddr == exv_pkg::REG_STATUS) begin
         status_ff <= (status_ff & ~pwdata[N-1:0]) | grant;
      end else begin
         status_ff <= status_ff | grant;
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         irq_ff <= 1'b0;
      end else begin
         irq_ff <= |(status_ff & mask_ff);
      end
   end

   assign prdata = prdata_ff;
   assign exc_take = take_ff;
   assign exc_offset = off_ff;
   assign exc_vector = vec_ff;
   assign machine_state_reg = mstate_ff;
   assign irq = irq_ff;

   ////////////////////////////////////////////////////////////////////////////
   // Checks
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rst_n);

   AST_IFETCH_VEC: assert property (
      core_evt.fetch_fault |=> exc_take && exc_offset == 14'h0400)
      else $error("Fetch fault not vectored to 0x0400");

   AST_DSI_VEC: assert property (
      core_evt.data_fault && !req[0]
      |=> exc_take && exc_offset == 14'h0300)
      else $error("Data fault not vectored to 0x0300");

   AST_ALIGN_VEC: assert property (
      core_evt.align_fault && req[1:0] == 2'h0
      |=> exc_take && exc_offset == 14'h0600)
      else $error("Alignment fault not vectored to 0x0600");

   AST_PROG_CAUSE: assert property (
      core_evt.prog_fault && req[2:0] == 3'h0
      |=> exc_take && exc_offset == 14'h0700 &&
      saved_state_reg_ff == $past(core_evt.prog_cause))
      else $error("Program fault vector or saved cause wrong");

   AST_FPU_VEC: assert property (
      exc_take && exc_offset == 14'h0800
      |-> $past(cand[exv_pkg::SRC_FPU]))
      else $error("Float unavailable taken without cause");

   AST_FPU_AVAIL: assert property (
      core_evt.fp_instr && !mstate_ff.float_available && req[3:0] == 4'h0
      |=> exc_take && exc_offset == 14'h0800)
      else $error("Float unavailable not vectored to 0x0800");

   AST_EXT_GATE: assert property (
      exc_take && exc_offset == 14'h0500
      |-> $past(ext_s2_ff && mstate_ff.external_irq_enable))
      else $error("External interrupt taken while not enabled");

   AST_DEC_SET: assert property (
      $rose(core_evt.dec_msb) && !mstate_ff.external_irq_enable
      |=> pend_ff[exv_pkg::SRC_DEC])
      else $error("Decrementer rise not held pending");

   AST_DEC_HOLD: assert property (
      pend_ff[exv_pkg::SRC_DEC] && !mstate_ff.external_irq_enable
      |=> pend_ff[exv_pkg::SRC_DEC])
      else $error("Disabled decrementer exception was dropped");

   AST_SYSCALL_VEC: assert property (
      core_evt.system_call_instr && req[4:0] == 5'h00
      |=> exc_take && exc_offset == 14'h0c00)
      else $error("System call not vectored to 0x0C00");

   AST_TRACE_VEC: assert property (
      mstate_ff.single_step_enable && core_evt.instr_done &&
      !core_evt.instr_is_rfi && req[5:0] == 6'h00
      |=> exc_take && exc_offset == 14'h0d00)
      else $error("Single step completion not traced");

   AST_FPA_VEC: assert property (
      core_evt.fp_assist && req[6:0] == 7'h00
      |=> exc_take && exc_offset == 14'h0e00)
      else $error("Float assist not vectored to 0x0E00");

   AST_IMPL_RANGE: assert property (
      exc_take && $past(grant[exv_pkg::SRC_IMPL_HI])
      |-> exc_offset >= 14'h1000 && exc_offset <= 14'h2fff)
      else $error("Implementation vector outside its range");

   AST_NO_RSVD: assert property (
      exc_take |-> exc_offset != 14'h0b00 &&
      !(exc_offset >= 14'h0e10 && exc_offset <= 14'h0fff) &&
      exc_vector == {$past(base_ff), exc_offset})
      else $error("Reserved vector or bad handler address");

   AST_ONE_WIN: assert property (
      take_now |-> $onehot(grant) ##1 exc_take)
      else $error("Coincident exceptions not resolved to one");

   COV_BACK2BACK: cover property (exc_take [*2]);
   COV_DEC_HELD: cover property (
      pend_ff[exv_pkg::SRC_DEC] && !mstate_ff.external_irq_enable ##1
      exc_take && exc_offset == 14'h0900);
   COV_EXT_TAKEN: cover property (exc_take && exc_offset == 14'h0500);
   COV_CLASH: cover property ($countones(req) > 1);

endmodule
`default_nettype wire

// ===== bench/exv_core_model.sv
// Core pipeline and external source model that drives exception conditions
`timescale 1ns/10ps
`default_nettype none
module exv_core_model (
   // Clock
   input wire logic clk,
   // Conditions toward the selector
   output var exv_pkg::exv_core_evt_t core_evt,
   output logic ext_irq_pin
);
   exv_pkg::exv_core_evt_t pulse_ff = '0;
   logic dec_ff = 1'b0;
   logic pin_ff = 1'b0;

   ////////////////////////////////////////
   // Decrementer MSB is a level laid over the one-cycle pulses
   always_comb begin
      core_evt = pulse_ff;
      core_evt.dec_msb = dec_ff;
   end
   // Pending request is a level held by the outside party
   assign ext_irq_pin = pin_ff;

   ////////////////////////////////////////
   // One-cycle pulse; cause and select fields travel with it
   task automatic fire(input exv_pkg::exv_core_evt_t e);
      @(posedge clk);
      pulse_ff <= e;
      @(posedge clk);
      pulse_ff <= '0;
   endtask
   task automatic set_pin(input logic v);
      pin_ff <= v;
   endtask
   task automatic set_dec(input logic v);
      dec_ff <= v;
   endtask
endmodule
`default_nettype wire

// ===== bench/exception_vector_select_tb_top.sv
// Self-checking bench for the exception vector selector
`timescale 1ns/10ps
`default_nettype none
module exception_vector_select_tb_top;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0000_0000;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   exv_pkg::exv_core_evt_t core_evt;
   logic ext_irq_pin;
   logic exc_take;
   logic [31:0] exc_vector;
   logic [13:0] exc_offset;
   exv_pkg::exv_mstate_t machine_state_reg;
   logic irq;
   int error_cnt = 0;
   int tests_run = 0;
   logic [31:0] base_val = 32'h8004_4000;

   always #2.5 clk = ~clk;

   exv_vector_select DUT (.clk(clk), .rst_n(rst_n), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .core_evt(core_evt), .ext_irq_pin(ext_irq_pin), .exc_take(exc_take),
      .exc_vector(exc_vector), .exc_offset(exc_offset),
      .machine_state_reg(machine_state_reg), .irq(irq));

   exv_core_model core (.clk(clk), .core_evt(core_evt),
      .ext_irq_pin(ext_irq_pin));

   ////////////////////////////////////////
   task automatic chk(input string name, input logic [31:0] seen,
      input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         error_cnt++;
         $display("ERROR %s expected %h seen %h", name, exp, seen);
      end
   endtask

   task automatic finish_test();
      $display("Checks %0d, mismatches %0d", tests_run, error_cnt);
      if (error_cnt == 0 && tests_run > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask

   // Samples taken in the edge's active region see pre-update values
   task automatic apb(input logic wr_en, input logic [11:0] addr,
      input logic [31:0] wd, output logic [31:0] rd, output logic err);
      int n;
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= wr_en;
      paddr <= addr;
      pwdata <= wd;
      @(posedge clk);
      penable <= 1'b1;
      for (n = 0; n < 20; n++) begin
         @(posedge clk);
         if (pready === 1'b1) break;
      end
      chk("pready", {31'h0, pready}, 32'h1);
      if (n == 20) finish_test();
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      logic [31:0] rd;
      logic err;
      apb(1'b1, a, d, rd, err);
   endtask

   task automatic rd_chk(input string name, input logic [11:0] a,
      input logic [31:0] exp);
      logic [31:0] rd;
      logic err;
      apb(1'b0, a, 32'h0, rd, err);
      chk(name, rd, exp);
   endtask

   task automatic take_ok(input logic [13:0] off, input int lim);
      int n;
      for (n = 0; n < lim; n++) begin
         @(posedge clk);
         if (exc_take === 1'b1) break;
      end
      chk("exc_take", {31'h0, exc_take}, 32'h1);
      if (n == lim) finish_test();
      chk("exc_offset", {18'h0, exc_offset}, {18'h0, off});
      chk("exc_vector", exc_vector, {base_val[31:14], off});
   endtask

   task automatic no_take(input string name, input int cyc);
      logic [31:0] c;
      c = 32'h0;
      repeat (cyc) begin
         @(posedge clk);
         if (exc_take !== 1'b0) c++;
      end
      chk(name, c, 32'h0);
   endtask

   // Reserved offsets must never reach the fetch unit
   always @(posedge clk) begin
      if (exc_take === 1'b1) chk("rsvd_offset", {31'h0,
         exc_offset == 14'h0b00 || (exc_offset >= 14'h0e10 &&
         exc_offset <= 14'h0fff)}, 32'h0);
   end

   ////////////////////////////////////////
   task automatic t_regs();
      logic [31:0] rd;
      logic err;
      rd_chk("mstate_rst", exv_pkg::REG_MSTATE, 32'h0);
      rd_chk("mask_rst", exv_pkg::REG_MASK, 32'h0);
      apb(1'b0, 12'h020, 32'h0, rd, err);
      chk("unmapped_err", {31'h0, err}, 32'h1);
      wr(exv_pkg::REG_MSTATE, 32'hf);
      @(posedge clk);
      chk("msr_port", {28'h0, machine_state_reg}, 32'hf);
      wr(exv_pkg::REG_BASE, base_val);
      rd_chk("base_rb", exv_pkg::REG_BASE, {base_val[31:14], 14'h0});
      $display("t_regs done");
   endtask

   // Each source alone except external and decrementer; single step on, float unavailable
   task automatic t_single();
      exv_pkg::exv_core_evt_t e;
      logic [13:0] ov [10];
      ov = '{exv_pkg::OFF_IFETCH, exv_pkg::OFF_DSI, exv_pkg::OFF_ALIGN,
         exv_pkg::OFF_PROG, exv_pkg::OFF_FPU, exv_pkg::OFF_SYSCALL,
         exv_pkg::OFF_TRACE, exv_pkg::OFF_FPA, exv_pkg::OFF_IMPL_LO,
         14'h2300};
      wr(exv_pkg::REG_MSTATE, 32'h4);
      for (int k = 0; k < 10; k++) begin
         e = '0;
         e.fetch_fault = (k == 0);
         e.data_fault = (k == 1);
         e.align_fault = (k == 2);
         e.prog_fault = (k == 3);
         e.prog_cause = 4'h9;
         e.fp_instr = (k == 4);
         e.system_call_instr = (k == 5);
         e.instr_done = (k == 6);
         e.fp_assist = (k == 7);
         e.impl_lo_req = (k == 8);
         e.impl_hi_req = (k == 9);
         // Select above 0x0f exercises the carry into the upper range
         e.impl_sel = 5'h13;
         core.fire(e);
         take_ok(ov[k],1);
      end
      rd_chk("saved_cause", exv_pkg::REG_SAVED, 32'h9);
      $display("t_single done");
   endtask

   task automatic t_irq();
      rd_chk("status", exv_pkg::REG_STATUS, 32'h3ff);
      chk("irq_masked", {31'h0, irq}, 32'h0);
      wr(exv_pkg::REG_MASK, 32'h2);
      repeat (2) @(posedge clk);
      chk("irq_on", {31'h0, irq}, 32'h1);
      wr(exv_pkg::REG_STATUS, 32'hfff);
      repeat (2) @(posedge clk);
      chk("irq_off", {31'h0, irq}, 32'h0);
      rd_chk("status_clr", exv_pkg::REG_STATUS, 32'h0);
      $display("t_irq done");
   endtask

   task automatic t_neg();
      exv_pkg::exv_core_evt_t e;
      wr(exv_pkg::REG_MSTATE, 32'h6);
      e = '0;
      e.fp_instr = 1'b1;
      core.fire(e);
      no_take("fp_avail", 4);
      e = '0;
      e.instr_done = 1'b1;
      e.instr_is_rfi = 1'b1;
      core.fire(e);
      no_take("rfi_step", 4);
      wr(exv_pkg::REG_MSTATE, 32'h8);
      e.instr_is_rfi = 1'b0;
      core.fire(e);
      no_take("no_branch", 4);
      e.branch_done = 1'b1;
      core.fire(e);
      take_ok(exv_pkg::OFF_TRACE, 1);
      $display("t_neg done");
   endtask

   // Four sources in one cycle come out one a cycle in fixed order
   task automatic t_prio();
      exv_pkg::exv_core_evt_t e;
      logic [13:0] ov [4];
      ov = '{exv_pkg::OFF_IFETCH, exv_pkg::OFF_DSI, exv_pkg::OFF_FPU,
         exv_pkg::OFF_SYSCALL};
      wr(exv_pkg::REG_MSTATE, 32'h0);
      e = '0;
      e.fetch_fault = 1'b1;
      e.data_fault = 1'b1;
      e.fp_instr = 1'b1;
      e.system_call_instr = 1'b1;
      core.fire(e);
      for (int k = 0; k < 4; k++) begin
         take_ok(ov[k], 1);
      end
      no_take("prio_extra", 4);
      $display("t_prio done");
   endtask

   task automatic t_ext();
      core.set_pin(1'b1);
      no_take("ext_disabled", 8);
      wr(exv_pkg::REG_MSTATE, 32'h1);
      take_ok(exv_pkg::OFF_EXT, 8);
      core.set_pin(1'b0);
      wr(exv_pkg::REG_MSTATE, 32'h0);
      no_take("ext_gone", 6);
      $display("t_ext done");
   endtask

   task automatic t_dec();
      core.set_dec(1'b1);
      no_take("dec_held", 6);
      rd_chk("dec_pend", exv_pkg::REG_PEND, 32'h800);
      wr(exv_pkg::REG_MSTATE, 32'h1);
      take_ok(exv_pkg::OFF_DEC, 4);
      no_take("dec_once", 6);
      core.set_dec(1'b0);
      wr(exv_pkg::REG_MSTATE, 32'h0);
      $display("t_dec done");
   endtask

   ////////////////////////////////////////
   initial begin
      repeat (5) @(posedge clk);
      rst_n <= 1'b1;
      t_regs();
      t_single();
      t_irq();
      t_neg();
      t_prio();
      t_ext();
      t_dec();
      finish_test();
   end
endmodule
`default_nettype wire
